// ==== hw/smc_defines.svh ====
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH
// Coprocessor selection
`define SMC_COPROC_NUM 4'hF
`define SMC_OPC1 3'h0
`define SMC_CRM 4'h0
`define SMC_OPC2 3'h0
`define SMC_CRN_CTRL 4'h1
`define SMC_CRN_TTB 4'h2
`define SMC_CRN_DAC 4'h3
// Control register fields
`define SMC_B_FI 21
`define SMC_B_L4 15
`define SMC_B_RR 14
`define SMC_B_V 13
`define SMC_B_I 12
`define SMC_B_Z 11
`define SMC_B_R 9
`define SMC_B_S 8
`define SMC_B_B 7
`define SMC_B_W 3
`define SMC_B_C 2
`define SMC_B_A 1
`define SMC_B_M 0
`define SMC_CTRL_SBO 32'h0000_0070
`define SMC_CTRL_RST 32'h0000_0008
`define SMC_TTB_LSB 14
`define SMC_TTB_RST 18'h0_0000
`define SMC_DAC_RST 32'h0000_0000
`define SMC_WB_SLOTS_FI 4'h4
`define SMC_WB_SLOTS_NORM 4'h8
`define SMC_VEC_HIGH 32'hFFFF_0000
`define SMC_VEC_LOW 32'h0000_0000
`endif

// ==== hw/smc_pkg.sv ====
package smc_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] coproc;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] secondary_reg_field;
    logic [2:0] opc2;
    logic [31:0] wdata;
  } smc_xfer_t;

  typedef struct packed {
    logic fast_irq_mode;
    logic [3:0] wb_slots;
    logic hit_under_miss;
    logic streaming_en;
    logic core_nonblocking;
    logic pc_load_state_legacy;
    logic round_robin_victim;
    logic [31:0] vector_base;
    logic icache_en;
    logic branch_pred_en;
    logic rom_prot_en;
    logic sys_prot_en;
    logic big_endian;
    logic wbuf_en;
    logic dcache_en;
    logic align_check_en;
    logic mmu_en;
  } smc_ctrl_t;

  typedef enum logic [1:0] {
    SMC_DOM_NONE = 2'b00,
    SMC_DOM_CLIENT = 2'b01,
    SMC_DOM_RSVD = 2'b10,
    SMC_DOM_MANAGER = 2'b11
  } smc_dom_t;
endpackage

// ==== hw/smc_decode.sv ====
`include "smc_defines.svh"
module smc_decode (
  input wire smc_pkg::smc_xfer_t xfer,
  output logic sel_ctrl,
  output logic sel_ttb,
  output logic sel_dac
);
  import smc_pkg::*;
  logic base_hit;
  // Coprocessor, opcode and secondary field must all match
  assign base_hit = xfer.valid && xfer.coproc == `SMC_COPROC_NUM && xfer.opc1 == `SMC_OPC1
    && xfer.secondary_reg_field == `SMC_CRM && xfer.opc2 == `SMC_OPC2;
  assign sel_ctrl = base_hit && xfer.crn == `SMC_CRN_CTRL;
  assign sel_ttb = base_hit && xfer.crn == `SMC_CRN_TTB;
  assign sel_dac = base_hit && xfer.crn == `SMC_CRN_DAC;
endmodule

// ==== hw/smc_domain_field.sv ====
module smc_domain_field (
  input wire logic [1:0] code,
  output logic allowed,
  output logic check_perm,
  output logic dom_fault
);
  import smc_pkg::*;
  smc_dom_t dom;
  assign dom = smc_dom_t'(code);
  always_comb begin
    allowed = 1'b0;
    check_perm = 1'b0;
    dom_fault = 1'b1;
    unique case (dom)
      SMC_DOM_NONE: begin
        dom_fault = 1'b1;
      end
      SMC_DOM_CLIENT: begin
        allowed = 1'b1;
        check_perm = 1'b1;
        dom_fault = 1'b0;
      end
      SMC_DOM_RSVD: begin
        dom_fault = 1'b1;
      end
      SMC_DOM_MANAGER: begin
        allowed = 1'b1;
        dom_fault = 1'b0;
      end
    endcase
  end
endmodule

// ==== hw/smc_regs.sv ====
// What this block does
// - Bit 21 fast-irq: four write slots, no hit-under-miss or streaming, blocking
// - Bits 31:22 read unpredictable; software writes zero or read-back value
// - Bit 15 set keeps state bit unchanged on PC loads
// - Bit 14 picks round-robin victim, else random; reset clears
// - Bit 13 puts vectors at high or low base
// - Bit 12 enables instruction cache; reset clears
// - Bit 11 enables branch prediction; reset clears
// - Bit 9 enables ROM protection; reset clears
// - Bit 8 enables system protection in both units; reset clears
// - Bit 7 selects big-endian when set
// - Bits 6:4 always read ones; software writes ones
// - Bit 3 enables write buffer; reset sets it
// - Bit 2 enables data cache; reset clears
// - Bit 1 enables alignment fault checking; reset clears
// - Bit 0 enables both memory management units; reset clears
// - Table base reads pointer in 31:14, low bits unpredictable
// - Table base write takes bits 31:14; software gives zero low bits
// - Domain register holds sixteen two-bit fields, domain 15 at top
// - Domain read returns all fields; write replaces all
// - Transfers use coprocessor 15, opcode 0, c0/0; c1,c2,c3 select registers
// - Vector and endian bits take synchronised strap levels on the third enabled clock after reset
// - Domain codes: none, client, reserved-as-none, manager
// - Every domain write invalidates unlocked translation buffer entries
`include "smc_defines.svh"
module smc_regs #(
  parameter int DOMAINS = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic high_vector_strap,
  input wire logic big_endian_strap,
  input wire smc_pkg::smc_xfer_t xfer,
  output logic xfer_ack,
  output logic [31:0] rdata,
  output smc_pkg::smc_ctrl_t ctrl,
  output logic [17:0] level1_table_pointer,
  output logic [31:0] domain_fields,
  output logic tlb_inval_unlocked,
  output logic [DOMAINS-1:0] dom_allowed,
  output logic [DOMAINS-1:0] dom_check_perm,
  output logic [DOMAINS-1:0] dom_fault
);
  import smc_pkg::*;
  logic sel_ctrl;
  logic sel_ttb;
  logic sel_dac;
  logic [31:0] ctrl_reg;
  logic [31:0] upper_hold;
  logic [1:0] strap_cnt;
  logic strap_load;
  logic [1:0] hv_sync;
  logic [1:0] be_sync;
  logic wr_ctrl;
  logic wr_ttb;
  logic wr_dac;
  logic [31:0] next_rdata;

  smc_decode u_decode (
    .xfer(xfer),
    .sel_ctrl(sel_ctrl),
    .sel_ttb(sel_ttb),
    .sel_dac(sel_dac)
  );

  assign wr_ctrl = clk_en && sel_ctrl && xfer.write;
  assign wr_ttb = clk_en && sel_ttb && xfer.write;
  assign wr_dac = clk_en && sel_dac && xfer.write;

  // Strap synchronisers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hv_sync <= 2'b00;
      be_sync <= 2'b00;
    end else if (clk_en) begin
      hv_sync <= {hv_sync[0], high_vector_strap};
      be_sync <= {be_sync[0], big_endian_strap};
    end
  end

  // Straps loaded once the synchronisers settle; a software write cancels the load
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_cnt <= 2'h0;
    end else if (wr_ctrl) begin
      strap_cnt <= 2'h3;
    end else if (clk_en && strap_cnt != 2'h3) begin
      strap_cnt <= strap_cnt + 2'h1;
    end
  end

  assign strap_load = clk_en && !wr_ctrl && strap_cnt == 2'h2;

  // Control register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= `SMC_CTRL_RST;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_reg <= 32'h0000_0000;
        ctrl_reg[`SMC_B_FI] <= xfer.wdata[`SMC_B_FI];
        ctrl_reg[`SMC_B_L4] <= xfer.wdata[`SMC_B_L4];
        ctrl_reg[`SMC_B_RR] <= xfer.wdata[`SMC_B_RR];
        ctrl_reg[`SMC_B_V] <= xfer.wdata[`SMC_B_V];
        ctrl_reg[`SMC_B_I] <= xfer.wdata[`SMC_B_I];
        ctrl_reg[`SMC_B_Z] <= xfer.wdata[`SMC_B_Z];
        ctrl_reg[`SMC_B_R] <= xfer.wdata[`SMC_B_R];
        ctrl_reg[`SMC_B_S] <= xfer.wdata[`SMC_B_S];
        ctrl_reg[`SMC_B_B] <= xfer.wdata[`SMC_B_B];
        ctrl_reg[`SMC_B_W] <= xfer.wdata[`SMC_B_W];
        ctrl_reg[`SMC_B_C] <= xfer.wdata[`SMC_B_C];
        ctrl_reg[`SMC_B_A] <= xfer.wdata[`SMC_B_A];
        ctrl_reg[`SMC_B_M] <= xfer.wdata[`SMC_B_M];
      end else if (strap_load) begin
        ctrl_reg[`SMC_B_V] <= hv_sync[1];
        ctrl_reg[`SMC_B_B] <= be_sync[1];
      end
    end
  end

  // Upper bits keep what software last wrote
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upper_hold <= 32'h0000_0000;
    end else if (clk_en && wr_ctrl) begin
      upper_hold <= {xfer.wdata[31:22], 22'h00_0000};
    end
  end

  // Translation table base
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level1_table_pointer <= `SMC_TTB_RST;
    end else if (wr_ttb) begin
      level1_table_pointer <= xfer.wdata[31:`SMC_TTB_LSB];
    end
  end

  // Domain access control
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      domain_fields <= `SMC_DAC_RST;
      tlb_inval_unlocked <= 1'b0;
    end else if (clk_en) begin
      tlb_inval_unlocked <= wr_dac;
      if (wr_dac) begin
        domain_fields <= xfer.wdata;
      end
    end
  end

  // Per-domain decode
  genvar gi;
  generate
    for (gi = 0; gi < DOMAINS; gi++) begin : g_dom
      smc_domain_field u_field (
        .code(domain_fields[2*gi+1:2*gi]),
        .allowed(dom_allowed[gi]),
        .check_perm(dom_check_perm[gi]),
        .dom_fault(dom_fault[gi])
      );
      dom_manager_a: assert property (@(posedge clk) disable iff (!resetn)
        domain_fields[2*gi+1:2*gi] == 2'h3 |-> dom_allowed[gi] && !dom_check_perm[gi])
        else $error("manager domain checks permissions");
    end
  endgenerate

  // Read data
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (sel_ctrl) begin
      next_rdata = (ctrl_reg & 32'h0000_FFFF) | {10'h000, ctrl_reg[21], 21'h00_0000};
      next_rdata = next_rdata | upper_hold | `SMC_CTRL_SBO;
    end else if (sel_ttb) begin
      next_rdata = {level1_table_pointer, 14'h0000};
    end else if (sel_dac) begin
      next_rdata = domain_fields;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h0000_0000;
      xfer_ack <= 1'b0;
    end else if (clk_en) begin
      xfer_ack <= sel_ctrl || sel_ttb || sel_dac;
      if (!xfer.write && (sel_ctrl || sel_ttb || sel_dac)) begin
        rdata <= next_rdata;
      end
    end
  end

  // Control outputs
  always_comb begin
    ctrl.fast_irq_mode = ctrl_reg[`SMC_B_FI];
    ctrl.wb_slots = ctrl_reg[`SMC_B_FI] ? `SMC_WB_SLOTS_FI : `SMC_WB_SLOTS_NORM;
    ctrl.hit_under_miss = !ctrl_reg[`SMC_B_FI];
    ctrl.streaming_en = !ctrl_reg[`SMC_B_FI];
    ctrl.core_nonblocking = !ctrl_reg[`SMC_B_FI];
    ctrl.pc_load_state_legacy = ctrl_reg[`SMC_B_L4];
    ctrl.round_robin_victim = ctrl_reg[`SMC_B_RR];
    ctrl.vector_base = ctrl_reg[`SMC_B_V] ? `SMC_VEC_HIGH : `SMC_VEC_LOW;
    ctrl.icache_en = ctrl_reg[`SMC_B_I];
    ctrl.branch_pred_en = ctrl_reg[`SMC_B_Z];
    ctrl.rom_prot_en = ctrl_reg[`SMC_B_R];
    ctrl.sys_prot_en = ctrl_reg[`SMC_B_S];
    ctrl.big_endian = ctrl_reg[`SMC_B_B];
    ctrl.wbuf_en = ctrl_reg[`SMC_B_W];
    ctrl.dcache_en = ctrl_reg[`SMC_B_C];
    ctrl.align_check_en = ctrl_reg[`SMC_B_A];
    ctrl.mmu_en = ctrl_reg[`SMC_B_M];
  end

  // Assertions
  property p_wr_next(logic sel, logic [31:0] d, logic bit_now, int b);
    @(posedge clk) disable iff (!resetn)
      (clk_en && sel && xfer.write) |=> (bit_now == $past(d[b]));
  endproperty

  sequence s_dac_write;
    clk_en && sel_dac && xfer.write;
  endsequence

  sequence s_idle_step;
    clk_en && !(sel_dac && xfer.write);
  endsequence

  sequence s_inval_pulse;
    tlb_inval_unlocked ##1 !tlb_inval_unlocked;
  endsequence

  fi_wbuf_slots_a: assert property (@(posedge clk) disable iff (!resetn)
    ctrl.wb_slots == (ctrl.fast_irq_mode ? 4'h4 : 4'h8)
    && ctrl.hit_under_miss == !ctrl.fast_irq_mode)
    else $error("write slots disagree with fast irq");
  fi_write_a: assert property (
    p_wr_next(sel_ctrl, xfer.wdata, ctrl.fast_irq_mode, 21))
    else $error("fast irq bit not written");
  fi_read_a: assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && sel_ctrl && !xfer.write) |=> rdata[21] == $past(ctrl.fast_irq_mode))
    else $error("fast irq bit read wrong");
  legacy_write_a: assert property (
    p_wr_next(sel_ctrl, xfer.wdata, ctrl.pc_load_state_legacy, 15))
    else $error("legacy load bit not written");
  rr_write_a: assert property (
    p_wr_next(sel_ctrl, xfer.wdata, ctrl.round_robin_victim, 14))
    else $error("victim policy bit not written");
  vector_base_a: assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && sel_ctrl && xfer.write) |=>
      ctrl.vector_base == ($past(xfer.wdata[13]) ? 32'hFFFF_0000 : 32'h0000_0000))
    else $error("vector base wrong");
  icache_write_a: assert property (
    p_wr_next(sel_ctrl, xfer.wdata, ctrl.icache_en, 12))
    else $error("icache enable not written");
  branch_write_a: assert property (
    p_wr_next(sel_ctrl, xfer.wdata, ctrl.branch_pred_en, 11))
    else $error("branch prediction bit not written");
  rom_prot_write_a: assert property (
    p_wr_next(sel_ctrl, xfer.wdata, ctrl.rom_prot_en, 9))
    else $error("rom protection bit not written");
  sys_prot_write_a: assert property (
    p_wr_next(sel_ctrl, xfer.wdata, ctrl.sys_prot_en, 8))
    else $error("system protection bit not written");
  endian_write_a: assert property (
    p_wr_next(sel_ctrl, xfer.wdata, ctrl.big_endian, 7))
    else $error("endian bit not written");
  ctrl_sbo_read_a: assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && sel_ctrl && !xfer.write) |=> rdata[6:4] == 3'h7)
    else $error("control read lacks ones");
  wbuf_write_a: assert property (
    p_wr_next(sel_ctrl, xfer.wdata, ctrl.wbuf_en, 3))
    else $error("write buffer bit not written");
  wbuf_reset_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(resetn) |-> ctrl.wbuf_en && !ctrl.mmu_en)
    else $error("reset values wrong");
  dcache_write_a: assert property (
    p_wr_next(sel_ctrl, xfer.wdata, ctrl.dcache_en, 2))
    else $error("dcache enable not written");
  align_write_a: assert property (
    p_wr_next(sel_ctrl, xfer.wdata, ctrl.align_check_en, 1))
    else $error("alignment check bit not written");
  mmu_en_write_a: assert property (
    p_wr_next(sel_ctrl, xfer.wdata, ctrl.mmu_en, 0))
    else $error("mmu enable not written");
  ttb_read_a: assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && sel_ttb && !xfer.write) |=> rdata[31:14] == $past(level1_table_pointer))
    else $error("table base read wrong");
  ttb_write_a: assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && sel_ttb && xfer.write) |=> level1_table_pointer == $past(xfer.wdata[31:14]))
    else $error("table base not written");
  dac_read_a: assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && sel_dac && !xfer.write) |=> rdata == $past(domain_fields))
    else $error("domain read wrong");
  ack_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && (sel_ctrl || sel_ttb || sel_dac)) |=> xfer_ack)
    else $error("decoded transfer not acknowledged");
  refused_no_ack_a: assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && !(sel_ctrl || sel_ttb || sel_dac)) |=> !xfer_ack)
    else $error("refused transfer acknowledged");
  strap_load_a: assert property (@(posedge clk) disable iff (!resetn)
    strap_load |=> ctrl.big_endian == $past(be_sync[1])
      && ctrl_reg[`SMC_B_V] == $past(hv_sync[1]))
    else $error("strap levels not loaded");
  dom_reserved_a: assert property (@(posedge clk) disable iff (!resetn)
    (domain_fields[3:2] == 2'h2) |-> dom_fault[1] && !dom_allowed[1])
    else $error("reserved domain allows access");
  dac_inval_a: assert property (@(posedge clk) disable iff (!resetn)
    s_dac_write |=> tlb_inval_unlocked && domain_fields == $past(xfer.wdata))
    else $error("domain write lacks invalidate");
  inval_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
    s_dac_write ##1 s_idle_step |-> s_inval_pulse)
    else $error("invalidate not a single pulse");
  freeze_a: assert property (@(posedge clk) disable iff (!resetn)
    !clk_en |=> $stable(ctrl_reg) && $stable(level1_table_pointer)
      && $stable(domain_fields) && $stable(xfer_ack))
    else $error("state moved while frozen");
endmodule

// ==== verif/smc_core_model.sv ====
module smc_core_model (
  input wire logic clk,
  input wire logic xfer_ack,
  input wire logic [31:0] rdata,
  output smc_pkg::smc_xfer_t xfer
);
  timeunit 1ns;
  timeprecision 1ns;
  import smc_pkg::*;
  initial xfer = '0;
  // One transfer per call: held up to the taking edge, answer sampled just after it
  task automatic raw(input logic wr, input logic [3:0] cp, input logic [3:0] crn,
    input logic [3:0] secondary_reg_field, input logic [2:0] op2, input logic [31:0] wd,
    output logic ack, output logic [31:0] rd);
    @(posedge clk);
    #1;
    xfer.valid = 1'b1;
    xfer.write = wr;
    xfer.coproc = cp;
    xfer.opc1 = 3'h0;
    xfer.crn = crn;
    xfer.secondary_reg_field = secondary_reg_field;
    xfer.opc2 = op2;
    xfer.wdata = wd;
    @(posedge clk);
    #1;
    xfer.valid = 1'b0;
    xfer.wdata = ~wd;
    ack = xfer_ack;
    rd = rdata;
  endtask
  task automatic cp_wr(input logic [3:0] crn, input logic [31:0] wd, output logic ack);
    logic [31:0] rd;
    raw(1'b1, 4'hF, crn, 4'h0, 3'h0, wd, ack, rd);
  endtask
  task automatic cp_rd(input logic [3:0] crn, output logic [31:0] d);
    logic ack;
    raw(1'b0, 4'hF, crn, 4'h0, 3'h0, 32'h0, ack, d);
  endtask
endmodule

// ==== verif/sysctl_mmu_config_regs_tb_top.sv ====
module sysctl_mmu_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import smc_pkg::*;
  localparam int BL [13] = '{21, 15, 14, 13, 12, 11, 9, 8, 7, 3, 2, 1, 0};
  localparam logic [14:0] BAD [4] = '{15'h7100, 15'h7A00, 15'h7901, 15'h7908};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic hv_strap = 1'b1;
  logic be_strap = 1'b1;
  smc_xfer_t xfer;
  logic xfer_ack;
  logic [31:0] rdata;
  smc_ctrl_t ctrl;
  logic [17:0] l1_ptr;
  logic [31:0] dom;
  logic tlb_inval;
  logic [15:0] d_allow;
  logic [15:0] d_chk;
  logic [15:0] d_flt;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  smc_regs smc_regs_i (.clk(clk), .resetn(resetn), .clk_en(clk_en),
    .high_vector_strap(hv_strap), .big_endian_strap(be_strap), .xfer(xfer),
    .xfer_ack(xfer_ack), .rdata(rdata), .ctrl(ctrl), .level1_table_pointer(l1_ptr),
    .domain_fields(dom), .tlb_inval_unlocked(tlb_inval), .dom_allowed(d_allow),
    .dom_check_perm(d_chk), .dom_fault(d_flt));
  smc_core_model smc_core_model_i (.clk(clk), .xfer_ack(xfer_ack), .rdata(rdata),
    .xfer(xfer));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Control outputs folded back into register bit positions
  function automatic logic [31:0] cbits(smc_ctrl_t c);
    cbits = '0;
    cbits[21] = c.fast_irq_mode;
    cbits[15] = c.pc_load_state_legacy;
    cbits[14] = c.round_robin_victim;
    cbits[13] = (c.vector_base === 32'hFFFF_0000);
    cbits[12] = c.icache_en;
    cbits[11] = c.branch_pred_en;
    cbits[9] = c.rom_prot_en;
    cbits[8] = c.sys_prot_en;
    cbits[7] = c.big_endian;
    cbits[3] = c.wbuf_en;
    cbits[2] = c.dcache_en;
    cbits[1] = c.align_check_en;
    cbits[0] = c.mmu_en;
  endfunction
  task automatic reset_check(input logic s);
    logic [31:0] d;
    hv_strap = s;
    be_strap = s;
    resetn = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("ctrl_out", cbits(ctrl), {18'h0, s, 5'h0, s, 7'h08});
    check("vector_base", ctrl.vector_base, s ? 32'hFFFF_0000 : 32'h0);
    smc_core_model_i.cp_rd(4'h1, d);
    check("ctrl_read", d, {18'h0, s, 5'h0, s, 7'h78});
    check("tt_ptr", {14'h0, l1_ptr}, 32'h0);
    check("dom", dom, 32'h0);
  endtask
  initial begin
    logic [31:0] d;
    logic [31:0] d2;
    logic a;
    reset_check(1'b1);
    foreach (BL[i]) begin
      smc_core_model_i.cp_wr(4'h1, 32'h70 | (32'h1 << BL[i]), a);
      check("ctrl_ack", {31'h0, a}, 32'h1);
      check("ctrl_out", cbits(ctrl), 32'h1 << BL[i]);
      check("vector_base", ctrl.vector_base, BL[i] == 13 ? 32'hFFFF_0000 : 32'h0);
      smc_core_model_i.cp_rd(4'h1, d);
      check("ctrl_read", d, 32'h70 | (32'h1 << BL[i]));
    end
    smc_core_model_i.cp_wr(4'h1, 32'h0020_0070, a);
    check("fi_set", {25'h0, ctrl.wb_slots, ctrl.hit_under_miss, ctrl.streaming_en,
      ctrl.core_nonblocking}, 32'h20);
    smc_core_model_i.cp_wr(4'h1, 32'h0000_5AFF, a);
    check("fi_clr", {25'h0, ctrl.wb_slots, ctrl.hit_under_miss, ctrl.streaming_en,
      ctrl.core_nonblocking}, 32'h47);
    smc_core_model_i.cp_rd(4'h1, d);
    smc_core_model_i.cp_wr(4'h1, d, a);
    smc_core_model_i.cp_rd(4'h1, d2);
    check("ctrl_rmw", d2, 32'h0000_5AFF);
    check("ctrl_out", cbits(ctrl), 32'h0000_5A8F);
    smc_core_model_i.cp_wr(4'h2, 32'hABCD_C000, a);
    check("tt_ptr", {14'h0, l1_ptr}, 32'hABCD_C000 >> 14);
    smc_core_model_i.cp_rd(4'h2, d);
    check("tt_read", d, 32'hABCD_C000);
    @(posedge clk);
    #1;
    clk_en = 1'b0;
    smc_core_model_i.cp_wr(4'h2, 32'h1234_4000, a);
    check("frozen_ack", {31'h0, a}, 32'h0);
    check("frozen_ptr", {14'h0, l1_ptr}, 32'hABCD_C000 >> 14);
    clk_en = 1'b1;
    foreach (BAD[k]) begin
      smc_core_model_i.raw(1'b1, BAD[k][14:11], BAD[k][10:7], BAD[k][6:3], BAD[k][2:0],
        32'h1234_4000, a, d);
      check("refused_ack", {31'h0, a}, 32'h0);
    end
    check("tt_ptr", {14'h0, l1_ptr}, 32'hABCD_C000 >> 14);
    smc_core_model_i.cp_wr(4'h3, 32'hE4E4_1B1B, a);
    check("dom", dom, 32'hE4E4_1B1B);
    check("tlb_inval", {31'h0, tlb_inval}, 32'h1);
    @(posedge clk);
    #1;
    check("tlb_inval", {31'h0, tlb_inval}, 32'h0);
    for (int i = 0; i < 16; i++) begin
      d = 32'hE4E4_1B1B >> (2 * i);
      d2 = d[1:0] == 2'b01 ? 32'h6 : (d[1:0] == 2'b11 ? 32'h4 : 32'h1);
      check("dom_decode", {29'h0, d_allow[i], d_chk[i], d_flt[i]}, d2);
    end
    smc_core_model_i.cp_rd(4'h3, d);
    check("dom_read", d, 32'hE4E4_1B1B);
    reset_check(1'b0);
    print_verdict();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
endmodule
